/* File: src/tsr_receiver.sv */
// Interrupt driven serial receiver with timer, interrupt unit and register port
// Operation
// (R1) Select high: test input is inverted line
// (R2) Arming disables timer interrupt before reprogramming
// (R3) Start detect: load all ones, event count
// (R4) Arming sets done flag; completion clears it
// (R5) Control byte armed to 11001011 binary
// (R6) Overflow when counter wraps from all ones
// (R7) External low level and timer overflow interrupt
// (R8) Vector 3 external, vector 7 timer
// (R9) Push program counter and status to stack
// (R10) Lock out interrupts until status-restoring return
// (R11) Return restores counter, status and bank
// (R12) Verified: reload period, sample, shift, decrement
// (R13) Count zero: clear done, disable timer interrupt
// (R14) First overflow: half period, timer mode, clear
// (R15) Verify start still space, else re-arm
// (R16) Period 41 counts, load two's complement
// (R17) Consumer polls done flag, then reads buffer
// (R18) Bits rotate right through carry
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "tsr_defs.svh"
module tsr_receiver #(
  parameter int BIT_PERIOD = `TSR_BIT_PERIOD,
  parameter int PRESCALE = `TSR_PRESCALE
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [`TSR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // Serial line and external interrupt pin
  input wire logic rx_line,
  input wire logic ext_int_n,
  // Status to the system
  output logic edge_polarity_select,
  output logic test_input_one,
  output logic [7:0] vector_addr,
  output logic irq
);
  // ==========================================================
  // Declarations
  // (R16) reload values are two's complements of the period and of half the period
  localparam logic [7:0] RELOAD_FULL = 8'(9'h100 - 9'(BIT_PERIOD));
  localparam logic [7:0] RELOAD_HALF = 8'(9'h100 - 9'(BIT_PERIOD / 2));
  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  tsr_pkg::tsr_state_t state_reg;
  tsr_pkg::tsr_state_t state_next;
  logic [7:0] control_count_byte;
  logic [7:0] serial_shift_buffer;
  logic carry_reg;
  logic receive_done_flag;
  logic tint_en_reg;
  logic tovf_pend_reg;
  logic ext_en_reg;
  logic arm_pend_reg;
  logic arm_in_isr_reg;
  logic locked_reg;
  logic [7:0] pc_reg;
  logic [7:0] program_status_word;
  logic [7:0] vec_reg;
  logic [7:0] stack_mem [`TSR_STACK_LO:`TSR_STACK_HI];
  logic [`TSR_IS_W-1:0] istat_reg;
  logic [`TSR_IS_W-1:0] imask_reg;
  logic [7:0] rdata_reg;
  logic [PW-1:0] pre_reg;
  logic tick;
  logic [7:0] cb_dec;
  logic ext_req;
  logic tmr_req;
  logic acc_ext;
  logic acc_tmr;
  logic ret_fire;
  logic [2:0] sp;
  logic [2:0] sp_dec;
  logic [4:0] push_idx;
  logic [4:0] pop_idx;
  logic wr_ctrl;
  logic reject;

  tsr_timer_if tif ();

  tsr_timer u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tif(tif)
  );

  // ==========================================================
  // Edge steering and timer prescaler
  // (R1) inverse of the line while select is high
  assign test_input_one = edge_polarity_select ^ rx_line;
  assign tif.event_in = test_input_one;
  assign tif.tick = tick;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
    end else if (pre_reg == PW'(PRESCALE - 1)) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PW'(1);
    end
  end
  assign tick = (pre_reg == PW'(PRESCALE - 1));

  // ==========================================================
  // Interrupt unit
  assign sp = program_status_word[2:0];
  assign sp_dec = sp - 3'd1;
  assign push_idx = 5'(`TSR_STACK_LO) + {1'b0, sp, 1'b0};
  assign pop_idx = 5'(`TSR_STACK_LO) + {1'b0, sp_dec, 1'b0};
  assign wr_ctrl = wr_stb && (addr == `TSR_A_CTRL);
  // (R7) low level on the pin, or a pending overflow
  assign ext_req = ext_en_reg && !ext_int_n;
  assign tmr_req = tint_en_reg && tovf_pend_reg;
  // (R10) nothing is accepted while locked; external wins a tie
  assign acc_ext = !locked_reg && ext_req;
  assign acc_tmr = !locked_reg && !ext_req && tmr_req && (state_reg == tsr_pkg::ST_IDLE);
  assign ret_fire = locked_reg && ((state_reg == tsr_pkg::ST_RET) ||
                    (wr_ctrl && wdata[`TSR_CTRL_RET] && vec_reg == `TSR_VEC_EXT));

  // (R10) lock from recognition until the return
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      locked_reg <= 1'b0;
    end else if (acc_ext || acc_tmr) begin
      locked_reg <= 1'b1;
    end else if (ret_fire) begin
      locked_reg <= 1'b0;
    end
  end

  // (R8) fixed call locations
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= 8'h00;
      vec_reg <= 8'h00;
    end else if (acc_ext || acc_tmr) begin
      pc_reg <= acc_ext ? `TSR_VEC_EXT : `TSR_VEC_TMR;
      vec_reg <= acc_ext ? `TSR_VEC_EXT : `TSR_VEC_TMR;
    end else if (ret_fire) begin
      // (R11) program counter comes back from the stack
      pc_reg <= stack_mem[pop_idx];
    end else if (wr_stb && addr == `TSR_A_PC) begin
      pc_reg <= wdata;
    end
  end

  // (R9) push counter then status word
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = `TSR_STACK_LO; i <= `TSR_STACK_HI; i++) begin
        stack_mem[i] <= 8'h00;
      end
    end else if (acc_ext || acc_tmr) begin
      stack_mem[push_idx] <= pc_reg;
      stack_mem[push_idx + 5'd1] <= program_status_word;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      program_status_word <= 8'h00;
    end else if (acc_ext || acc_tmr) begin
      program_status_word[2:0] <= sp + 3'd1;
    end else if (ret_fire) begin
      // (R11) restores status and with it the bank
      program_status_word <= stack_mem[pop_idx + 5'd1];
    end else if (state_reg == tsr_pkg::ST_SERVE) begin
      // Service runs in the alternate register bank
      program_status_word[`TSR_PSW_BANK] <= 1'b1;
    end else if (wr_stb && addr == `TSR_A_PSW) begin
      program_status_word <= wdata;
    end
  end

  // Overflow pending: a new overflow beats the clear of acceptance
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tovf_pend_reg <= 1'b0;
    end else if (tif.ovf) begin
      tovf_pend_reg <= 1'b1;
    end else if (acc_tmr || state_reg == tsr_pkg::ST_ARM_LOAD) begin
      tovf_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Receive sequencer
  assign cb_dec = control_count_byte - 8'h01;
  assign reject = (state_reg == tsr_pkg::ST_SERVE) &&
                  control_count_byte[`TSR_CB_NOT_VERIFIED] &&
                  !control_count_byte[`TSR_CB_NOT_DETECTED] && rx_line;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tsr_pkg::ST_IDLE: begin
        if (acc_tmr) begin
          state_next = tsr_pkg::ST_SERVE;
        end else if (arm_pend_reg) begin
          state_next = tsr_pkg::ST_ARM_DIS;
        end
      end
      tsr_pkg::ST_ARM_DIS: state_next = tsr_pkg::ST_ARM_LOAD;
      tsr_pkg::ST_ARM_LOAD: begin
        state_next = arm_in_isr_reg ? tsr_pkg::ST_RET : tsr_pkg::ST_IDLE;
      end
      tsr_pkg::ST_SERVE: begin
        // (R15) a line back at mark re-arms from scratch
        state_next = reject ? tsr_pkg::ST_ARM_DIS : tsr_pkg::ST_RET;
      end
      tsr_pkg::ST_RET: state_next = tsr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= tsr_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Arm requests wait until the sequencer is free
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arm_pend_reg <= 1'b0;
    end else if (wr_ctrl && wdata[`TSR_CTRL_ARM]) begin
      arm_pend_reg <= 1'b1;
    end else if (state_reg == tsr_pkg::ST_IDLE && !acc_tmr) begin
      arm_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arm_in_isr_reg <= 1'b0;
    end else if (state_reg == tsr_pkg::ST_SERVE) begin
      arm_in_isr_reg <= reject;
    end else if (state_reg == tsr_pkg::ST_IDLE) begin
      arm_in_isr_reg <= 1'b0;
    end
  end

  // Timer commands
  always_comb begin
    tif.load = 1'b0;
    tif.load_val = RELOAD_FULL;
    tif.start = 1'b0;
    tif.stop = 1'b0;
    tif.event_mode = 1'b0;
    unique case (state_reg)
      tsr_pkg::ST_ARM_DIS: tif.stop = 1'b1;
      tsr_pkg::ST_ARM_LOAD: begin
        // (R3) one more event overflows the counter
        tif.load = 1'b1;
        tif.load_val = `TSR_TMR_ALL_ONES;
        tif.start = 1'b1;
        tif.event_mode = 1'b1;
      end
      tsr_pkg::ST_SERVE: begin
        if (control_count_byte[`TSR_CB_NOT_VERIFIED] &&
            control_count_byte[`TSR_CB_NOT_DETECTED]) begin
          // (R14) half a bit to the start bit centre
          tif.load = 1'b1;
          tif.load_val = RELOAD_HALF;
          tif.start = 1'b1;
        end else if (!reject) begin
          // (R12) (R15) full bit period to the next centre
          tif.load = 1'b1;
          tif.start = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // Control/count byte, buffer and carry
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      control_count_byte <= 8'h00;
      serial_shift_buffer <= 8'h00;
      carry_reg <= 1'b0;
    end else if (state_reg == tsr_pkg::ST_ARM_LOAD) begin
      // (R5) not verified, not detected, eleven bits
      control_count_byte <= `TSR_CB_ARM;
    end else if (state_reg == tsr_pkg::ST_SERVE) begin
      if (!control_count_byte[`TSR_CB_NOT_VERIFIED]) begin
        // (R12) (R18) sample then rotate right through carry
        serial_shift_buffer <= {rx_line, serial_shift_buffer[7:1]};
        carry_reg <= serial_shift_buffer[0];
        control_count_byte <= cb_dec;
      end else if (control_count_byte[`TSR_CB_NOT_DETECTED]) begin
        // (R14) start now detected
        control_count_byte[`TSR_CB_NOT_DETECTED] <= 1'b0;
      end else if (!rx_line) begin
        // (R15) start verified
        control_count_byte[`TSR_CB_NOT_VERIFIED] <= 1'b0;
      end
    end
  end

  // Done flag and timer interrupt enable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      receive_done_flag <= 1'b0;
      tint_en_reg <= 1'b0;
    end else if (state_reg == tsr_pkg::ST_ARM_DIS) begin
      // (R2) disabled in the cycle the timer is stopped, before it is reloaded
      tint_en_reg <= 1'b0;
    end else if (state_reg == tsr_pkg::ST_ARM_LOAD) begin
      // (R4) set while a character is outstanding
      receive_done_flag <= 1'b1;
      tint_en_reg <= 1'b1;
    end else if (state_reg == tsr_pkg::ST_SERVE &&
                 !control_count_byte[`TSR_CB_NOT_VERIFIED] && cb_dec == 8'h00) begin
      // (R13) (R4) character complete
      receive_done_flag <= 1'b0;
      tint_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      edge_polarity_select <= 1'b0;
    end else if (state_reg == tsr_pkg::ST_ARM_LOAD) begin
      // (R1) start edge steered onto the test input
      edge_polarity_select <= 1'b1;
    end else if (state_reg == tsr_pkg::ST_SERVE && !reject &&
                 control_count_byte[`TSR_CB_NOT_VERIFIED] &&
                 !control_count_byte[`TSR_CB_NOT_DETECTED]) begin
      edge_polarity_select <= 1'b0;
    end
  end

  // ==========================================================
  // Event status, mask and register port
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      istat_reg <= '0;
    end else begin
      // Hardware set wins over a write-one clear in the same cycle
      istat_reg <= (istat_reg & ~((wr_stb && addr == `TSR_A_ISTAT) ?
                    wdata[`TSR_IS_W-1:0] : '0)) |
                   {acc_ext, reject,
                    state_reg == tsr_pkg::ST_SERVE &&
                    !control_count_byte[`TSR_CB_NOT_VERIFIED] && cb_dec == 8'h00};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      imask_reg <= '0;
      ext_en_reg <= 1'b0;
    end else if (wr_stb && addr == `TSR_A_IMASK) begin
      imask_reg <= wdata[`TSR_IS_W-1:0];
    end else if (wr_ctrl) begin
      ext_en_reg <= wdata[`TSR_CTRL_EXTEN];
    end
  end

  assign irq = |(istat_reg & imask_reg);
  assign vector_addr = pc_reg;

  // (R17) consumer polls the done flag, then reads the buffer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        `TSR_A_CTRL: rdata_reg <= 8'(ext_en_reg) << `TSR_CTRL_EXTEN;
        `TSR_A_STAT: rdata_reg <= {4'h0, locked_reg, tint_en_reg,
                                   edge_polarity_select, receive_done_flag};
        `TSR_A_BUF: rdata_reg <= serial_shift_buffer;
        `TSR_A_CB: rdata_reg <= control_count_byte;
        `TSR_A_ISTAT: rdata_reg <= 8'(istat_reg);
        `TSR_A_IMASK: rdata_reg <= 8'(imask_reg);
        `TSR_A_PC: rdata_reg <= pc_reg;
        `TSR_A_PSW: rdata_reg <= program_status_word;
        `TSR_A_VEC: rdata_reg <= vec_reg;
        `TSR_A_TMR: rdata_reg <= tif.count;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // ==========================================================
  // Checks
  select_invert_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R1)
    edge_polarity_select |-> (test_input_one == !rx_line))
    else $error("test input not the inverted line");
  arm_order_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R2)
    (state_reg == tsr_pkg::ST_ARM_DIS) |=> (!tint_en_reg && !tif.running && tif.load))
    else $error("timer reloaded before interrupt disabled");
  arm_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R3)
    (state_reg == tsr_pkg::ST_ARM_LOAD) |=> (tif.count == `TSR_TMR_ALL_ONES &&
      receive_done_flag && control_count_byte == `TSR_CB_ARM && tint_en_reg))
    else $error("arming left wrong timer, flag or control byte");
  call_vector_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R8)
    acc_tmr |=> (pc_reg == `TSR_VEC_TMR && state_reg == tsr_pkg::ST_SERVE))
    else $error("timer call went to wrong location");
  stack_push_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R9)
    (acc_ext || acc_tmr) |=> (sp == $past(sp) + 3'd1 &&
      stack_mem[$past(push_idx)] == $past(pc_reg)))
    else $error("interrupt call did not push");
  lockout_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R10)
    (locked_reg && !ret_fire) |=> (locked_reg && !acc_ext && !acc_tmr))
    else $error("interrupt accepted while locked");
  return_bank_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R11)
    ret_fire |=> (program_status_word == $past(stack_mem[pop_idx + 5'd1]) && !locked_reg))
    else $error("return did not restore status word");
  char_done_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R13)
    (state_reg == tsr_pkg::ST_SERVE && control_count_byte == 8'h01)
      |=> (!receive_done_flag && !tint_en_reg) ##1 (state_reg == tsr_pkg::ST_IDLE))
    else $error("last bit did not finish the character");
  half_bit_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R14)
    (state_reg == tsr_pkg::ST_SERVE && control_count_byte[7:6] == 2'b11)
      |=> (tif.count == RELOAD_HALF && !control_count_byte[`TSR_CB_NOT_DETECTED]))
    else $error("start detect did not load half period");
endmodule

/* File: src/tsr_defs.svh */
// Constants of the timer driven serial receiver
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH

// ==========================================================
// Register map (8-bit data, 4-bit address)
`define TSR_ADDR_W 4
`define TSR_A_CTRL 4'h0
`define TSR_A_STAT 4'h1
`define TSR_A_BUF 4'h2
`define TSR_A_CB 4'h3
`define TSR_A_ISTAT 4'h4
`define TSR_A_IMASK 4'h5
`define TSR_A_PC 4'h6
`define TSR_A_PSW 4'h7
`define TSR_A_VEC 4'h8
`define TSR_A_TMR 4'h9

// ==========================================================
// Field positions
`define TSR_CTRL_ARM 0
`define TSR_CTRL_RET 1
`define TSR_CTRL_EXTEN 2
`define TSR_CB_NOT_VERIFIED 7
`define TSR_CB_NOT_DETECTED 6
`define TSR_IS_CHAR 0
`define TSR_IS_REJECT 1
`define TSR_IS_EXT 2
`define TSR_IS_W 3
`define TSR_PSW_BANK 4

// ==========================================================
// Values
`define TSR_CB_ARM 8'hCB
`define TSR_TMR_ALL_ONES 8'hFF
`define TSR_VEC_EXT 8'h03
`define TSR_VEC_TMR 8'h07
`define TSR_STACK_LO 8
`define TSR_STACK_HI 23
`define TSR_BIT_PERIOD 41
`define TSR_PRESCALE 32

`endif

/* File: src/tsr_pkg.sv */
// Types of the timer driven serial receiver
package tsr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM_DIS,
    ST_ARM_LOAD,
    ST_SERVE,
    ST_RET
  } tsr_state_t;
endpackage

/* File: src/tsr_timer_if.sv */
// Command and status bundle between the receiver and its 8-bit timer
`timescale 1ns/10ps
interface tsr_timer_if;
  logic load;
  logic [7:0] load_val;
  logic start;
  logic stop;
  logic event_mode;
  logic event_in;
  logic tick;
  logic ovf;
  logic [7:0] count;
  logic running;
  modport ctl(output load, load_val, start, stop, event_mode, event_in, tick,
              input ovf, count, running);
  modport tmr(input load, load_val, start, stop, event_mode, event_in, tick,
              output ovf, count, running);
endinterface

/* File: src/tsr_timer.sv */
// 8-bit up-counting timer with timer and event count modes
`timescale 1ns/10ps
`include "tsr_defs.svh"
module tsr_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Control side
  tsr_timer_if.tmr tif
);
  logic [7:0] count_reg;
  logic run_reg;
  logic mode_reg;
  logic ev_prev_reg;
  logic ovf_reg;
  logic inc;

  // Events count on the rising edge of the test input
  // A stop freezes the count at once, so a stopped run leaves no late overflow
  assign inc = run_reg && !tif.stop &&
               (mode_reg ? (tif.event_in && !ev_prev_reg) : tif.tick);

  // Reset to the idle level of the test input: no false edge after reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ev_prev_reg <= 1'b1;
    end else begin
      ev_prev_reg <= tif.event_in;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else if (tif.start) begin
      run_reg <= 1'b1;
      mode_reg <= tif.event_mode;
    end else if (tif.stop) begin
      run_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 8'h00;
    end else if (tif.load) begin
      count_reg <= tif.load_val;
    end else if (inc) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // (R6) wrap from all ones
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= inc && !tif.load && (count_reg == `TSR_TMR_ALL_ONES);
    end
  end

  assign tif.count = count_reg;
  assign tif.running = run_reg;
  assign tif.ovf = ovf_reg;

  overflow_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // (R6)
    (inc && !tif.load && count_reg == `TSR_TMR_ALL_ONES) |=> (ovf_reg && count_reg == 8'h00))
    else $error("timer wrap gave no overflow");
endmodule

/* File: tb/tsr_tx_model.sv */
// Serial transmitter model that drives the receive line
`timescale 1ns/10ps
module tsr_tx_model (
  // Clock
  input wire logic clk_sys,
  // Serial line, 1 is mark
  output logic rx_line
);
  // ==========================================================
  // Idle line
  initial begin
    rx_line = 1'b1;
  end

  // ==========================================================
  // Frame: start space, then 11 bits, bit 0 first
  task automatic send_frame(input logic [10:0] frame, input int per);
    int i;
    @(posedge clk_sys);
    rx_line <= 1'b0;
    repeat (per) @(posedge clk_sys);
    for (i = 0; i < 11; i++) begin
      rx_line <= frame[i];
      repeat (per) @(posedge clk_sys);
    end
    rx_line <= 1'b1;
  endtask

  // Space pulse too short to be a start bit, line back at mark afterwards
  task automatic glitch(input int len);
    @(posedge clk_sys);
    rx_line <= 1'b0;
    repeat (len) @(posedge clk_sys);
    rx_line <= 1'b1;
  endtask
endmodule

/* File: tb/tb.sv */
// Testbench of the timer driven serial receiver
`timescale 1ns/10ps
`include "tsr_defs.svh"
module tb;
  // Short prescale keeps the run brief while reload latency stays small per bit
  localparam int PRE = 4;
  localparam int PER = `TSR_BIT_PERIOD * PRE;
  logic clk_sys;
  logic arst_n;
  logic [`TSR_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata;
  logic rx_line;
  logic ext_int_n;
  logic edge_polarity_select;
  logic test_input_one;
  logic [7:0] vector_addr;
  logic irq;
  int error_cnt;
  int cmp_count;
  int cyc;

  tsr_receiver #(.BIT_PERIOD(`TSR_BIT_PERIOD), .PRESCALE(PRE)) u_tsr_receiver (
    .clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .rx_line(rx_line), .ext_int_n(ext_int_n),
    .edge_polarity_select(edge_polarity_select), .test_input_one(test_input_one),
    .vector_addr(vector_addr), .irq(irq));
  tsr_tx_model u_tsr_tx_model (.clk_sys(clk_sys), .rx_line(rx_line));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk_reg(d, exp);
  endtask

  // One character: done must hold until late in the frame, then fall
  task automatic rx_char(input logic [10:0] frame);
    logic [7:0] d;
    int n;
    fork
      u_tsr_tx_model.send_frame(frame, PER);
    join_none
    tick(11 * PER);
    rd(`TSR_A_STAT, d);
    chk_pin(d[0], 1'b1);
    n = 0;
    while (d[0] !== 1'b0 && n < 400) begin
      rd(`TSR_A_STAT, d);
      n++;
    end
    chk_pin(d[0], 1'b0);
    rc(`TSR_A_BUF, frame[10:3]);
    rc(`TSR_A_STAT, 8'h00);
    rc(`TSR_A_CB, 8'h00);
    rc(`TSR_A_VEC, 8'h07);
    rc(`TSR_A_ISTAT, 8'h01);
    chk_pin(irq, 1'b1);
    chk_pin(test_input_one, rx_line);
    wr(`TSR_A_ISTAT, 8'h01);
    tick(2 * PER);
    chk_pin(irq, 1'b0);
  endtask

  task automatic arm_chk();
    wr(`TSR_A_CTRL, 8'h01);
    tick(4);
    rc(`TSR_A_CB, 8'hCB);
    rc(`TSR_A_TMR, 8'hFF);
    rc(`TSR_A_STAT, 8'h07);
    chk_pin(edge_polarity_select, 1'b1);
    chk_pin(test_input_one, ~rx_line);
  endtask

  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    arst_n = 1'b0;
    addr = '0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ext_int_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rc(`TSR_A_STAT, 8'h00);
    rc(4'hF, 8'h00);
    chk_pin(irq, 1'b0);
    wr(`TSR_A_IMASK, 8'h03);
    rc(`TSR_A_IMASK, 8'h03);
    arm_chk();
    // Start that is gone at verify time is refused and the receiver re-arms
    u_tsr_tx_model.glitch(10);
    tick(PER + 40);
    rc(`TSR_A_ISTAT, 8'h02);
    rc(`TSR_A_CB, 8'hCB);
    chk_pin(irq, 1'b1);
    wr(`TSR_A_ISTAT, 8'h02);
    tick(2);
    chk_pin(irq, 1'b0);
    rx_char(11'h6A5);
    arm_chk();
    rx_char(11'h75A);
    // External call, lockout while the pin stays low, then return
    wr(`TSR_A_PC, 8'h5A);
    wr(`TSR_A_PSW, 8'h00);
    wr(`TSR_A_CTRL, 8'h04);
    ext_int_n <= 1'b0;
    tick(20);
    chk_reg(vector_addr, 8'h03);
    rc(`TSR_A_PSW, 8'h01);
    rc(`TSR_A_ISTAT, 8'h04);
    rc(`TSR_A_STAT, 8'h08);
    // Service switches bank; the return must bring the old bank back
    wr(`TSR_A_PSW, 8'h11);
    ext_int_n <= 1'b1;
    wr(`TSR_A_CTRL, 8'h06);
    tick(3);
    chk_reg(vector_addr, 8'h5A);
    rc(`TSR_A_PSW, 8'h00);
    rc(`TSR_A_STAT, 8'h00);
    stop_test();
  end
endmodule
